// >>> hdl/sbcc_if.sv
// Backplane signals between the bus master and a peripheral card
`timescale 1ns/10ps
interface sbcc_if;
    import sbcc_pkg::*;
    logic              clock_b;
    logic              mcsync_b;
    logic              memrq_b;
    logic              iorq_b;
    logic              rd_b;
    logic              wr_b;
    logic              intak_b;
    logic              intrq_b;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data_m_out;
    logic              data_m_oe_b;
    logic [DATA_W-1:0] data_p_out;
    logic              data_p_oe_b;
    logic [DATA_W-1:0] data;
    // Wire level of the shared data bus; the master owns it on write and T1
    assign data = !data_m_oe_b ? data_m_out : (!data_p_oe_b ? data_p_out : '1);
    modport master (
        output clock_b, mcsync_b, memrq_b, iorq_b, rd_b, wr_b, intak_b, addr,
        output data_m_out, data_m_oe_b,
        input  intrq_b, data
    );
    modport periph (
        input  clock_b, mcsync_b, memrq_b, iorq_b, rd_b, wr_b, intak_b, addr, data,
        output intrq_b, data_p_out, data_p_oe_b
    );
endinterface : sbcc_if

// >>> hdl/sbcc_master.sv
// Bus master end: time state clock and bus-cycle sequencing
`timescale 1ns/10ps
module sbcc_master
    import sbcc_pkg::*;
(
    input  wire logic                      mclk,
    input  wire logic                      rst_b,
    input  wire logic                      osc_in,
    input  wire logic                      req_valid,
    input  wire sbcc_pkg::sbcc_op_t        req_op,
    input  wire logic [sbcc_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [sbcc_pkg::DATA_W-1:0] req_wdata,
    input  wire logic                      int_enable,
    output logic                           req_ready,
    output logic                           rsp_valid,
    output logic [sbcc_pkg::DATA_W-1:0]    rsp_rdata,
    output logic [sbcc_pkg::DATA_W-1:0]    latched_addr_lo,
    sbcc_if.master                         bus
);
    import sbcc_pkg::*;

    // ------------------------------------------------------------
    // Oscillator input synchroniser and divide by two
    // ------------------------------------------------------------
    logic [PIN_SYNC_FF-1:0] osc_sync;
    logic                   osc_level;
    logic                   osc_rise;
    logic                   ts_clk;
    logic                   ts_tick;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            osc_sync <= '0;
        end else begin
            osc_sync <= {osc_sync[PIN_SYNC_FF-2:0], osc_in};
        end
    end

    // A change counts only once the second and third stages agree
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            osc_level <= 1'b0;
        end else if (osc_sync[1] == osc_sync[2]) begin
            osc_level <= osc_sync[2];
        end
    end

    assign osc_rise = (osc_sync[1] == osc_sync[2]) && osc_sync[2] && !osc_level;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ts_clk <= 1'b0;
        end else if (osc_rise) begin
            ts_clk <= ~ts_clk;
        end
    end

    // Boundary: time state clock about to rise
    assign ts_tick = osc_rise && !ts_clk;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            bus.clock_b <= 1'b1;
        end else begin
            bus.clock_b <= ~ts_clk;
        end
    end

    // ------------------------------------------------------------
    // Interrupt request synchroniser
    // ------------------------------------------------------------
    logic [PIN_SYNC_FF-1:0] irq_sync;
    logic                   irq_level;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            irq_sync <= '1;
        end else begin
            irq_sync <= {irq_sync[PIN_SYNC_FF-2:0], bus.intrq_b};
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            irq_level <= 1'b0;
        end else if (irq_sync[1] == irq_sync[2]) begin
            irq_level <= !irq_sync[2];
        end
    end

    // ------------------------------------------------------------
    // Machine-cycle sequencer
    // ------------------------------------------------------------
    sbcc_tstate_t tstate;
    sbcc_op_t     op;
    logic [DATA_W-1:0] wdata;

    function automatic logic op_is_read(input sbcc_op_t o);
        op_is_read = (o == SBCC_OP_MEM_RD) || (o == SBCC_OP_IO_RD) || (o == SBCC_OP_INT_ACK);
    endfunction : op_is_read

    // An acknowledge is issued only while a request is pending and int_enable is high; otherwise it is held off in idle until both hold
    logic start_ok;
    assign start_ok = (req_op != SBCC_OP_INT_ACK) || (irq_level && int_enable);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tstate <= SBCC_T_IDLE;
            op     <= SBCC_OP_MEM_RD;
            wdata  <= '0;
            bus.addr <= '0;
        end else if (ts_tick) begin
            unique case (tstate)
                SBCC_T_IDLE: begin
                    if (req_valid && start_ok) begin
                        tstate   <= SBCC_T_1;
                        op       <= req_op;
                        wdata    <= req_wdata;
                        bus.addr <= req_addr;
                    end
                end
                SBCC_T_1: tstate <= SBCC_T_2;
                SBCC_T_2: tstate <= SBCC_T_3;
                SBCC_T_3: tstate <= SBCC_T_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            req_ready <= 1'b0;
        end else begin
            req_ready <= (tstate == SBCC_T_IDLE) && !(ts_tick && req_valid && start_ok);
        end
    end

    // ------------------------------------------------------------
    // Strobes
    // ------------------------------------------------------------
    logic strobe_phase;
    assign strobe_phase = (tstate == SBCC_T_2) || (tstate == SBCC_T_3);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            bus.mcsync_b <= 1'b1;
            bus.memrq_b  <= 1'b1;
            bus.iorq_b   <= 1'b1;
            bus.rd_b     <= 1'b1;
            bus.wr_b     <= 1'b1;
            bus.intak_b  <= 1'b1;
        end else begin
            bus.mcsync_b <= !(tstate == SBCC_T_1);
            // Exactly one space and one direction per cycle
            bus.memrq_b <= !((tstate != SBCC_T_IDLE) &&
                             (op == SBCC_OP_MEM_RD || op == SBCC_OP_MEM_WR));
            bus.iorq_b  <= !((tstate != SBCC_T_IDLE) &&
                             (op == SBCC_OP_IO_RD || op == SBCC_OP_IO_WR ||
                              op == SBCC_OP_INT_ACK));
            bus.rd_b    <= !(strobe_phase && op != SBCC_OP_INT_ACK && op_is_read(op));
            bus.wr_b    <= !(strobe_phase && !op_is_read(op));
            bus.intak_b <= !(strobe_phase && op == SBCC_OP_INT_ACK);
        end
    end

    // Master drives the address in T1 and write data thereafter
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            bus.data_m_out  <= '0;
            bus.data_m_oe_b <= 1'b1;
        end else begin
            bus.data_m_out  <= (tstate == SBCC_T_1) ? bus.addr[DATA_W-1:0] : wdata;
            bus.data_m_oe_b <= !((tstate == SBCC_T_1) ||
                                 (strobe_phase && !op_is_read(op)));
        end
    end

    // ------------------------------------------------------------
    // Address latch and read capture
    // ------------------------------------------------------------
    // Catch the low byte at the edge that releases the cycle-start strobe;
    // one cycle later the shared lines already carry write data
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            latched_addr_lo <= '0;
        end else if (!bus.mcsync_b && (tstate != SBCC_T_1)) begin
            latched_addr_lo <= bus.data;
        end
    end

    // Read data is taken at the end of T3, where strobes are still held
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            rsp_valid <= ts_tick && (tstate == SBCC_T_3);
            if (ts_tick && tstate == SBCC_T_3 && op_is_read(op)) begin
                rsp_rdata <= bus.data;
            end
        end
    end
endmodule : sbcc_master

// >>> hdl/sbcc_periph.sv
// Peripheral card end: memory, one input port, one output port, interrupt source
`timescale 1ns/10ps
module sbcc_periph
    import sbcc_pkg::*;
#(
    parameter int MEM_DEPTH = 256
)(
    input  wire logic                        mclk,
    input  wire logic                        rst_b,
    input  wire logic [sbcc_pkg::DATA_W-1:0] in_port,
    input  wire logic                        irq_raise,
    input  wire logic [sbcc_pkg::DATA_W-1:0] int_vector,
    output logic [sbcc_pkg::DATA_W-1:0]      out_port,
    output logic                             out_strobe,
    sbcc_if.periph                           bus
);
    import sbcc_pkg::*;
    localparam int AW = $clog2(MEM_DEPTH);

    // Depths below two words or beyond the address space cannot be decoded
    if (MEM_DEPTH < 2 || MEM_DEPTH > (1 << ADDR_W)) begin : g_depth_check
        $error("MEM_DEPTH out of range");
    end

    // ------------------------------------------------------------
    // Strobe decode
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem [MEM_DEPTH];
    logic mem_rd;
    logic mem_wr;
    logic io_rd;
    logic io_wr;
    logic wr_q;

    assign mem_rd = !bus.memrq_b && !bus.rd_b;
    assign mem_wr = !bus.memrq_b && !bus.wr_b;
    assign io_rd  = !bus.iorq_b && !bus.rd_b;
    assign io_wr  = !bus.iorq_b && !bus.wr_b;

    always_ff @(posedge mclk) begin
        if (mem_wr && !wr_q) begin
            mem[bus.addr[AW-1:0]] <= bus.data;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q       <= 1'b0;
            out_port   <= '0;
            out_strobe <= 1'b0;
        end else begin
            wr_q       <= !bus.wr_b;
            out_strobe <= io_wr && !wr_q;
            if (io_wr && !wr_q) begin
                out_port <= bus.data;
            end
        end
    end

    // Read data from one clock after the strobe falls to one clock after it rises, so the bus is never fought
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            bus.data_p_out  <= '0;
            bus.data_p_oe_b <= 1'b1;
        end else begin
            bus.data_p_oe_b <= !(mem_rd || io_rd || !bus.intak_b);
            if (!bus.intak_b) begin
                bus.data_p_out <= int_vector;
            end else if (io_rd) begin
                bus.data_p_out <= in_port;
            end else begin
                bus.data_p_out <= mem[bus.addr[AW-1:0]];
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt request: held until acknowledged; raise wins over clear
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            bus.intrq_b <= 1'b1;
        end else if (irq_raise) begin
            bus.intrq_b <= 1'b0;
        end else if (!bus.intak_b) begin
            bus.intrq_b <= 1'b1;
        end
    end
endmodule : sbcc_periph

// >>> hdl/sbcc_pkg.sv
// Shared constants and types for the bus-cycle control block
package sbcc_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int  MCLK_PERIOD_NS = 10;
    localparam int  OSC_DIV        = 2;
    localparam int  PIN_SYNC_FF    = 3;
    localparam logic RESET_SYNC_LVL = 1'b1;
    // ------------------------------------------------------------
    // Cycle kinds
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SBCC_OP_MEM_RD  = 3'b000,
        SBCC_OP_MEM_WR  = 3'b001,
        SBCC_OP_IO_RD   = 3'b010,
        SBCC_OP_IO_WR   = 3'b011,
        SBCC_OP_INT_ACK = 3'b100
    } sbcc_op_t;
    // Time states of one machine cycle
    typedef enum logic [1:0] {
        SBCC_T_IDLE = 2'b00,
        SBCC_T_1    = 2'b01,
        SBCC_T_2    = 2'b10,
        SBCC_T_3    = 2'b11
    } sbcc_tstate_t;
endpackage : sbcc_pkg

// >>> testbench/sbcc_checker.sv
// Concurrent checks on the backplane signals between the two ends
`timescale 1ns/10ps
module sbcc_checker
    import sbcc_pkg::*;
#(
    parameter int OSC_HALF = 8
)(
    input wire logic                        mclk,
    input wire logic                        rst_b,
    input wire logic                        clock_b,
    input wire logic                        mcsync_b,
    input wire logic                        memrq_b,
    input wire logic                        iorq_b,
    input wire logic                        rd_b,
    input wire logic                        wr_b,
    input wire logic                        intak_b,
    input wire logic                        intrq_b,
    input wire logic [sbcc_pkg::ADDR_W-1:0] addr
);
    // ------------------------------------------------------------
    // Time state clock level counter
    // ------------------------------------------------------------
    logic [5:0] run;
    logic       clk_q;
    logic       armed;
    logic       chg;
    assign chg = clock_b != clk_q;
    // First level after reset is partial, so only judge once armed
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            run   <= 6'h00;
            clk_q <= 1'h1;
            armed <= 1'h0;
        end else begin
            clk_q <= clock_b;
            armed <= armed | chg;
            run   <= chg ? 6'h00 : run + 6'h01;
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    chk_rd_wr_apart: assert property (!(!rd_b && !wr_b))
        else $error("read and write strobes low together");
    chk_rq_apart: assert property (!((!rd_b || !wr_b) && !memrq_b && !iorq_b))
        else $error("memory and io requests low together");
    chk_rd_qualified: assert property (!rd_b |-> memrq_b != iorq_b)
        else $error("read strobe without one request line");
    chk_wr_qualified: assert property (!wr_b |-> memrq_b != iorq_b)
        else $error("write strobe without one request line");
    chk_intak_cause: assert property ($fell(intak_b) |-> !intrq_b && !iorq_b && rd_b)
        else $error("interrupt fetch without pending request");
    chk_tstate_half: assert property (chg && armed |-> run == 2 * OSC_HALF - 1)
        else $error("time state clock level length wrong");
    chk_strobe_span: assert property ($fell(rd_b & wr_b & intak_b) |-> ##[56:72] $rose(rd_b & wr_b & intak_b))
        else $error("strobe not two time states long");
    chk_sync_first: assert property ($fell(rd_b & wr_b & intak_b) |-> mcsync_b && (!memrq_b || !iorq_b))
        else $error("strobe before cycle start ended");
    chk_sync_pulse: assert property ($fell(mcsync_b) |-> ##[1:32] $rose(mcsync_b))
        else $error("cycle start pulse too long");
    chk_addr_steady: assert property (!rd_b && !$past(rd_b) |-> $stable(addr))
        else $error("address moved during read strobe");
endmodule : sbcc_checker

// >>> testbench/std_bus_cycle_control_bench.sv
// Self-checking bench: master and peripheral ends joined on one backplane
`timescale 1ns/10ps
module std_bus_cycle_control_bench;
    import sbcc_pkg::*;
    localparam int OSC_HALF = 8;
    logic                mclk, rst_b, osc_in, req_valid, int_enable, irq_raise;
    logic                req_ready, rsp_valid, out_strobe;
    sbcc_op_t            req_op;
    logic [ADDR_W-1:0]   req_addr;
    logic [DATA_W-1:0]   req_wdata, in_port, int_vector, rsp_rdata, latched_addr_lo, out_port;
    logic [DATA_W-1:0]   rd;
    int                  num_errors, num_checks, cycles, strobes;
    sbcc_if sbcc_if_i ();
    sbcc_master sbcc_master_i (.mclk(mclk), .rst_b(rst_b), .osc_in(osc_in),
        .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
        .int_enable(int_enable), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .latched_addr_lo(latched_addr_lo), .bus(sbcc_if_i));
    sbcc_periph sbcc_periph_i (.mclk(mclk), .rst_b(rst_b), .in_port(in_port),
        .irq_raise(irq_raise), .int_vector(int_vector), .out_port(out_port),
        .out_strobe(out_strobe), .bus(sbcc_if_i));
    sbcc_checker #(.OSC_HALF(OSC_HALF)) sbcc_checker_i (.mclk(mclk), .rst_b(rst_b),
        .clock_b(sbcc_if_i.clock_b), .mcsync_b(sbcc_if_i.mcsync_b),
        .memrq_b(sbcc_if_i.memrq_b), .iorq_b(sbcc_if_i.iorq_b), .rd_b(sbcc_if_i.rd_b),
        .wr_b(sbcc_if_i.wr_b), .intak_b(sbcc_if_i.intak_b), .intrq_b(sbcc_if_i.intrq_b),
        .addr(sbcc_if_i.addr));
    // ------------------------------------------------------------
    // Clocks, watchdog and shared tasks
    // ------------------------------------------------------------
    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end
    always begin
        repeat (OSC_HALF) @(negedge mclk);
        osc_in = ~osc_in;
    end
    always @(negedge mclk) begin
        strobes = strobes + (out_strobe === 1'h1);
        cycles++;
        if (cycles > 20000) begin
            num_errors++;
            wrap_up();
        end
    end
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Request is held until the answer pulse; a late irq proves an early ack is refused
    task automatic run_op(input sbcc_op_t op, input logic [15:0] a, input logic [7:0] wd,
                          input bit late, output logic [7:0] got);
        int n;
        n = 0;
        @(negedge mclk);
        while (req_ready !== 1'h1 && n < 1000) begin
            @(negedge mclk);
            n++;
        end
        req_op    = op;
        req_addr  = a;
        req_wdata = wd;
        req_valid = 1'h1;
        n = 0;
        while (rsp_valid !== 1'h1 && n < 1000) begin
            @(negedge mclk);
            n++;
            irq_raise = late && n == 300;
        end
        got       = rsp_rdata;
        req_valid = 1'h0;
        check({7'h00, n < 1000}, 8'h01);
        if (late)
            check({7'h00, n > 300}, 8'h01);
        else
            check(latched_addr_lo, a[7:0]);
    endtask : run_op
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [15:0] adr [3] = '{16'h0000, 16'h00ff, 16'h0010};
        logic [7:0]  dat [3] = '{8'h5a, 8'hc3, 8'h77};
        rst_b = 1'h0;
        osc_in = 1'h0;
        req_valid = 1'h0;
        req_op = SBCC_OP_MEM_RD;
        req_addr = 16'h0000;
        req_wdata = 8'h00;
        int_enable = 1'h1;
        in_port = 8'ha5;
        irq_raise = 1'h0;
        int_vector = 8'h3c;
        num_errors = 0;
        num_checks = 0;
        cycles = 0;
        strobes = 0;
        repeat (20) @(negedge mclk);
        rst_b = 1'h1;
        for (int i = 0; i < 3; i++)
            run_op(SBCC_OP_MEM_WR, adr[i], dat[i], 1'b0, rd);
        run_op(SBCC_OP_IO_WR, 16'h0010, 8'h96, 1'b0, rd);
        repeat (2) @(negedge mclk);
        check(out_port, 8'h96);
        check(strobes[7:0], 8'h01);
        for (int i = 0; i < 3; i++) begin
            run_op(SBCC_OP_MEM_RD, adr[i], 8'h00, 1'b0, rd);
            check(rd, dat[i]);
        end
        run_op(SBCC_OP_IO_RD, 16'h0020, 8'h00, 1'b0, rd);
        check(rd, 8'ha5);
        run_op(SBCC_OP_INT_ACK, 16'h0000, 8'h00, 1'b1, rd);
        check(rd, 8'h3c);
        check(strobes[7:0], 8'h01);
        wrap_up();
    end
endmodule : std_bus_cycle_control_bench
